// ---- shared/lcis_pkg.sv ----
// constants and types of the led current serial programming slave
// assumes one 50 mhz system clock that samples the two-wire bus pins
package lcis_pkg;

	// system clock
	localparam int unsigned CLK_PERIOD_NS = 20;

	// bus address and byte selector values
	localparam logic [6:0] SLAVE_ADDR     = 7'h39;
	localparam logic       WRITE_BIT      = 1'b0;
	localparam logic [7:0] SEL_BACKLIGHT  = 8'h01;
	localparam logic [7:0] SEL_FLASH      = 8'h02;

	// register selector offsets, equal to the selector byte values
	localparam logic [7:0] BACKLIGHT_LEVEL_OFS = 8'h01;
	localparam logic [7:0] FLASH_LEVEL_OFS     = 8'h02;

	// field layout of the two level registers
	localparam int unsigned BK_CODE_W     = 5;
	localparam int unsigned FL_CODE_W     = 7;
	localparam int unsigned BK_CONNECT_POS = 7;
	localparam logic [7:0]  BK_KEEP_MASK  = 8'h9f;
	localparam logic [7:0]  FL_KEEP_MASK  = 8'h7f;

	// mirror gain
	localparam int unsigned GAIN_FACTOR = 40;
	localparam int unsigned BK_GAIN_W   = 11;
	localparam int unsigned FL_GAIN_W   = 13;

	// values after reset
	localparam logic [7:0] LEVEL_RESET = 8'h00;
	localparam logic [1:0] LINE_RESET  = 2'h3;

	// frame counting
	localparam logic [1:0] BYTE_ADDR  = 2'h0;
	localparam logic [1:0] BYTE_SEL   = 2'h1;
	localparam logic [1:0] BYTE_DATA  = 2'h2;
	localparam logic [3:0] LAST_BIT   = 4'h7;
	localparam logic [3:0] FULL_CNT   = 4'h8;

	// frame states
	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_RECV = 4'b0010,
		ST_ACK  = 4'b0100,
		ST_SKIP = 4'b1000
	} lcis_state_t;

endpackage

// ---- shared/lcis_line_if.sv ----
// synchronised bus levels and bus events between line stage and frame logic
// assumes both ends run on the same system clock
`timescale 1ns/1ps
`default_nettype none
interface lcis_line_if;
	logic scl;
	logic sda;
	logic scl_rise;
	logic scl_fall;
	logic start;
	logic stop;

	modport drv (output scl, sda, scl_rise, scl_fall, start, stop);
	modport use_side (input scl, sda, scl_rise, scl_fall, start, stop);
endinterface
`default_nettype wire

// ---- rtl/lcis_line_sync.sv ----
// two-flop synchroniser and edge / start / stop detection for scl and sda
// assumes raw pin levels, already resolved from the open-drain wires
`timescale 1ns/1ps
`default_nettype none
module lcis_line_sync
	import lcis_pkg::*;
(
	// clock and reset
	input  wire logic   clock_i,
	input  wire logic   reset_i,
	// raw pins
	input  wire logic   scl_i,
	input  wire logic   sda_i,
	// synchronised view
	lcis_line_if.drv    line
);

	////////////////////////////////////////////////////////////////////////
	// bit 1 is scl, bit 0 is sda
	typedef struct packed {
		logic [1:0] meta;
		logic [1:0] sync;
		logic [1:0] prev;
	} lcis_sync_t;

	lcis_sync_t q;
	lcis_sync_t d;

	always_comb begin
		d      = q;
		d.meta = {scl_i, sda_i};
		d.sync = q.meta;
		d.prev = q.sync;
	end

	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			q <= '{LINE_RESET, LINE_RESET, LINE_RESET};
		end else begin
			q <= d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// only sync and prev are looked at; meta feeds sync alone
	assign line.scl      = q.sync[1];
	assign line.sda      = q.sync[0];
	assign line.scl_rise = q.sync[1] & ~q.prev[1];
	assign line.scl_fall = ~q.sync[1] & q.prev[1];
	assign line.start    = q.sync[1] & q.prev[1] & ~q.sync[0] & q.prev[0];
	assign line.stop     = q.sync[1] & q.prev[1] & q.sync[0] & ~q.prev[0];

endmodule // lcis_line_sync
`default_nettype wire

// ---- rtl/led_current_i2c_slave.sv ----
// write-only two-wire slave holding the backlight and flash level registers
// assumes open-drain pins resolved outside; scl slow against the 50 mhz clock
`timescale 1ns/1ps
`default_nettype none
module led_current_i2c_slave
	import lcis_pkg::*;
(
	// clock and reset
	input  wire logic                          clock_i,
	input  wire logic                          reset_i,
	// two-wire bus pins
	input  wire logic                          scl_i,
	input  wire logic                          sda_i,
	output logic                               sda_o,
	output logic                               sda_oe_o,
	// level outputs to the analog section
	output logic [lcis_pkg::BK_CODE_W-1:0]     backlight_level_o,
	output logic                               fourth_backlight_connect_o,
	output logic [lcis_pkg::FL_CODE_W-1:0]     flash_level_o,
	output logic [lcis_pkg::BK_GAIN_W-1:0]     backlight_gain_o,
	output logic [lcis_pkg::FL_GAIN_W-1:0]     flash_gain_o,
	output logic                               pump_enable_o
);

	import lcis_pkg::*;

	////////////////////////////////////////////////////////////////////////
	typedef struct packed {
		lcis_state_t            st;
		logic [1:0]             byte_idx;
		logic [3:0]             bit_cnt;
		logic [7:0]             shift;
		logic [7:0]             sel;
		logic [7:0]             bk;
		logic [7:0]             fl;
		logic [BK_GAIN_W-1:0]   bk_gain;
		logic [FL_GAIN_W-1:0]   fl_gain;
		logic                   pump;
		logic                   sda_oe;
	} lcis_frame_t;

	lcis_frame_t q;
	lcis_frame_t d;
	logic [7:0]  byte_w;
	logic        byte_end;
	logic        load_bk;
	logic        load_fl;
	logic        sel_ok;

	lcis_line_if line ();

	lcis_line_sync u_line_sync (
		.clock_i (clock_i),
		.reset_i (reset_i),
		.scl_i   (scl_i),
		.sda_i   (sda_i),
		.line    (line)
	);

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		d        = q;
		byte_w   = {q.shift[6:0], line.sda};
		byte_end = (q.st == ST_RECV) && line.scl_rise
			&& (q.bit_cnt == LAST_BIT);
		sel_ok   = (q.sel == SEL_BACKLIGHT) || (q.sel == SEL_FLASH);
		load_bk  = byte_end && (q.byte_idx == BYTE_DATA)
			&& (q.sel == SEL_BACKLIGHT);
		load_fl  = byte_end && (q.byte_idx == BYTE_DATA)
			&& (q.sel == SEL_FLASH);
		case (q.st)
			ST_RECV: begin
				if (line.scl_rise && (q.bit_cnt < FULL_CNT)) begin
					d.shift   = byte_w;
					d.bit_cnt = q.bit_cnt + 4'h1;
				end
				if (byte_end) begin
					case (q.byte_idx)
						BYTE_ADDR: begin
							if (byte_w != {SLAVE_ADDR, WRITE_BIT}) begin
								d.st = ST_SKIP;
							end
						end
						BYTE_SEL: begin
							d.sel = byte_w;
							if ((byte_w != SEL_BACKLIGHT)
								&& (byte_w != SEL_FLASH)) begin
								d.st = ST_SKIP;
							end
						end
						default: begin
						end
					endcase
				end
				// ack goes out only after scl has fallen, so sda
				// never moves while scl is high
				if (line.scl_fall && (q.bit_cnt == FULL_CNT)) begin
					d.st     = ST_ACK;
					d.sda_oe = 1'b1;
				end
			end
			ST_ACK: begin
				if (line.scl_fall) begin
					d.sda_oe  = 1'b0;
					d.bit_cnt = 4'h0;
					if (q.byte_idx == BYTE_DATA) begin
						d.st = ST_SKIP;
					end else begin
						d.st       = ST_RECV;
						d.byte_idx = q.byte_idx + 2'h1;
					end
				end
			end
			default: begin
			end
		endcase
		if (load_bk) begin
			d.bk = byte_w & BK_KEEP_MASK;
		end
		if (load_fl) begin
			d.fl = byte_w & FL_KEEP_MASK;
		end
		if (line.stop) begin
			d.st     = ST_IDLE;
			d.sda_oe = 1'b0;
		end else if (line.start) begin
			d.st       = ST_RECV;
			d.byte_idx = BYTE_ADDR;
			d.bit_cnt  = 4'h0;
			d.sda_oe   = 1'b0;
		end
		d.bk_gain = BK_GAIN_W'(GAIN_FACTOR * d.bk[BK_CODE_W-1:0]);
		d.fl_gain = FL_GAIN_W'(GAIN_FACTOR * d.fl[FL_CODE_W-1:0]);
		d.pump    = (d.bk != LEVEL_RESET) || (d.fl != LEVEL_RESET);
	end

	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			q          <= '0;
			q.st       <= ST_IDLE;
			q.bk       <= LEVEL_RESET;
			q.fl       <= LEVEL_RESET;
		end else begin
			q <= d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// scl has no output at all; sda is only ever pulled low
	assign sda_o                      = 1'b0;
	assign sda_oe_o                   = q.sda_oe;
	assign backlight_level_o          = q.bk[BK_CODE_W-1:0];
	assign fourth_backlight_connect_o = q.bk[BK_CONNECT_POS];
	assign flash_level_o              = q.fl[FL_CODE_W-1:0];
	assign backlight_gain_o           = q.bk_gain;
	assign flash_gain_o               = q.fl_gain;
	assign pump_enable_o              = q.pump;

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (reset_i);

	sequence s_ack_begin;
		(q.st == ST_RECV) && (q.bit_cnt == FULL_CNT) && line.scl_fall
			&& !line.start && !line.stop;
	endsequence

	sequence s_ack_end;
		sda_oe_o && line.scl_fall && !line.start && !line.stop;
	endsequence

	a_gain_backlight: assert property (
		##1 backlight_gain_o == BK_GAIN_W'(40 * backlight_level_o))
		else $error("backlight gain not forty times the code");

	a_pump_enable: assert property (
		##1 pump_enable_o == ((backlight_level_o != 5'h00)
			|| fourth_backlight_connect_o || (flash_level_o != 7'h00)))
		else $error("pump enable disagrees with register contents");

	a_reserved_zero: assert property (
		(q.bk[6:5] == 2'h0) && (q.fl[7] == 1'b0))
		else $error("reserved register bits not zero");

	// the reset itself also clears the levels, so that edge is left out
	a_load_moment: assert property (
		!$past(reset_i) && ($changed(q.bk) || $changed(q.fl))
			|-> $past(byte_end) && ($past(q.byte_idx) == BYTE_DATA)
			&& $past(sel_ok))
		else $error("level register changed outside third byte end");

	a_select_legal: assert property (
		(byte_end && (q.byte_idx == BYTE_SEL)
			&& (byte_w != SEL_BACKLIGHT) && (byte_w != SEL_FLASH))
			|=> (q.st == ST_SKIP) && $stable(q.bk) && $stable(q.fl))
		else $error("unknown selector changed a register");

	a_addr_match: assert property (
		(q.st == ST_ACK) && (q.byte_idx == BYTE_ADDR)
			|-> q.shift == {SLAVE_ADDR, WRITE_BIT})
		else $error("address acknowledged without a match");

	a_fourth_led: assert property (
		load_bk |=> fourth_backlight_connect_o == $past(byte_w[7])
			&& backlight_level_o == $past(byte_w[4:0]))
		else $error("backlight write did not store connect bit");

	a_ack_window: assert property (
		s_ack_begin |=> sda_oe_o && !sda_o)
		else $error("acknowledge not driven after eighth bit");

	a_ack_release: assert property (
		s_ack_end |=> !sda_oe_o)
		else $error("sda still driven after acknowledge clock");

	a_reset_clear: assert property (
		$past(reset_i) |-> !pump_enable_o && (backlight_level_o == 5'h00)
			&& (flash_level_o == 7'h00))
		else $error("levels not cleared after reset");

endmodule // led_current_i2c_slave
`default_nettype wire

// ---- testbench/lcis_master_model.sv ----
// two-wire bus master model that writes frames to the level slave
// assumes a pull-up on sda; the slave only pulls low through sda_oe_i
`timescale 1ns/1ps
`default_nettype none
module lcis_master_model (
	// clock
	input  wire logic clock_i,
	// slave pull-down
	input  wire logic sda_oe_i,
	// resolved wires
	output logic      scl_o,
	output logic      sda_o
);
	logic sda_m = 1'b1;
	initial scl_o = 1'b1;
	// released sda floats to the pull-up level
	assign sda_o = sda_m & ~sda_oe_i;

	//////////////////////////////////////////////////////////////////////
	// every step holds six clocks so sync and edge stages settle
	task automatic put(input logic c, input logic d);
		@(posedge clock_i);
		scl_o <= c;
		sda_m <= d;
		repeat (5) @(posedge clock_i);
	endtask

	// n bytes msb first in one start..stop; between start and stop sda moves only while scl low
	task automatic frame(input logic [31:0] b, input int n,
		output logic [3:0] ak);
		ak = 4'h0;
		put(1'b1, 1'b1);
		put(1'b1, 1'b0);
		put(1'b0, 1'b0);
		for (int i = 0; i < n; i++) begin
			for (int j = 31 - 8 * i; j > 23 - 8 * i; j--) begin
				put(1'b0, b[j]);
				put(1'b1, b[j]);
				put(1'b0, b[j]);
			end
			put(1'b0, 1'b1);
			put(1'b1, 1'b1);
			ak[i] = !sda_o;
			put(1'b0, 1'b1);
		end
		put(1'b0, 1'b0);
		put(1'b1, 1'b0);
		put(1'b1, 1'b1);
	endtask
endmodule // lcis_master_model
`default_nettype wire

// ---- testbench/test_led_current_i2c_slave.sv ----
// self-checking bench for the level slave against an integer model
// assumes the master model resolves the open-drain sda wire
`timescale 1ns/1ps
`default_nettype none
module test_led_current_i2c_slave;
	import lcis_pkg::*;
	logic        clock_i = 1'b0;
	logic        reset_i = 1'b1;
	logic        scl, sda, sda_o, sda_oe, con, pump;
	logic [4:0]  bk_lvl;
	logic [6:0]  fl_lvl;
	logic [10:0] bk_gain;
	logic [12:0] fl_gain;
	int          errors = 0;
	int          comparisons = 0;
	int          m_bk = 0, m_con = 0, m_fl = 0;

	initial forever #10 clock_i = ~clock_i;

	lcis_master_model mst (.clock_i(clock_i), .sda_oe_i(sda_oe),
		.scl_o(scl), .sda_o(sda));
	led_current_i2c_slave DUT (.clock_i(clock_i), .reset_i(reset_i),
		.scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe),
		.backlight_level_o(bk_lvl), .fourth_backlight_connect_o(con),
		.flash_level_o(fl_lvl), .backlight_gain_o(bk_gain),
		.flash_gain_o(fl_gain), .pump_enable_o(pump));

	//////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [12:0] g, input logic [12:0] e);
		comparisons++;
		if (g !== e) begin
			errors++;
			$display("[ERR] %0t got %h expected %h", $time, g, e);
		end
	endtask

	// sampled at the falling edge so register updates have landed
	task automatic outs();
		@(negedge clock_i);
		chk({8'h0, bk_lvl}, 13'(m_bk));
		chk({12'h0, con}, 13'(m_con));
		chk({6'h0, fl_lvl}, 13'(m_fl));
		chk({2'h0, bk_gain}, 13'(40 * m_bk));
		chk(fl_gain, 13'(40 * m_fl));
		chk({12'h0, pump}, 13'(m_bk + m_con + m_fl != 0));
		chk({12'h0, sda_o}, 13'h0);
	endtask

	task automatic run(input logic [7:0] a, s, d, input int n);
		logic [3:0] ak;
		logic       ad, ok;
		ad = (a == {SLAVE_ADDR, WRITE_BIT});
		ok = ad && (s == 8'h01 || s == 8'h02);
		mst.frame({a, s, d, 8'h5a}, n, ak);
		if (ok && n > 2 && s == 8'h01) begin
			m_bk = d[4:0];
			m_con = d[7];
		end
		if (ok && n > 2 && s == 8'h02) begin
			m_fl = d[6:0];
		end
		chk({9'h0, ak}, {10'h0, ok && n > 2, ok && n > 1, ad});
		outs();
	endtask

	task automatic wrap_up();
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	//////////////////////////////////////////////////////////////////////
	initial begin
		#1000000;
		errors++;
		wrap_up();
	end

	initial begin
		void'($urandom(32'hc963));
		repeat (20) @(posedge clock_i);
		reset_i <= 1'b0;
		@(posedge clock_i);
		outs();
		run(8'h72, 8'h01, 8'h9f, 3);
		run(8'h72, 8'h02, 8'h7f, 3);
		run(8'h72, 8'h01, 8'h00, 3);
		run(8'h72, 8'h02, 8'h80, 3);
		run(8'h72, 8'h01, 8'h80, 3);
		run(8'h72, 8'h01, 8'h65, 3);
		run(8'h72, 8'h03, 8'h55, 3);
		run(8'h72, 8'h00, 8'h55, 3);
		run(8'h70, 8'h01, 8'h11, 3);
		run(8'h73, 8'h01, 8'h11, 3);
		run(8'h72, 8'h02, 8'h33, 2);
		run(8'h72, 8'h02, 8'h2c, 4);
		repeat (20) begin
			run($urandom % 2 ? 8'h72 : 8'($urandom), 8'($urandom % 4),
				8'($urandom), 3);
		end
		// reset again after the last frame: both levels must clear
		@(posedge clock_i);
		reset_i <= 1'b1;
		repeat (2) @(posedge clock_i);
		reset_i <= 1'b0;
		m_bk = 0;
		m_con = 0;
		m_fl = 0;
		@(posedge clock_i);
		outs();
		wrap_up();
	end
endmodule // test_led_current_i2c_slave
`default_nettype wire
